/* File: bdpi_map.svh */
// register offsets, control field positions and timing constants of the bus dma block
`ifndef BDPI_MAP_SVH
`define BDPI_MAP_SVH
// register offsets as byte addresses on the data lines
`define BDPI_OFS_ADDR 3'h0
`define BDPI_OFS_WCNT 3'h2
`define BDPI_OFS_CTL 3'h4
`define BDPI_OFS_DATA 3'h6
`define BDPI_OFS_MASK 3'h6
// control register bit positions
`define BDPI_CTL_START 0
`define BDPI_CTL_RESET 1
`define BDPI_CTL_DATIN 2
`define BDPI_CTL_DATIO 3
`define BDPI_CTL_XAD16 4
`define BDPI_CTL_XAD17 5
`define BDPI_CTL_ATTN 6
`define BDPI_CTL_READY 7
`define BDPI_CTL_AFLAG 8
`define BDPI_CTL_BFLAG 9
`define BDPI_CTL_BEN 12
`define BDPI_CTL_AREQ 13
`define BDPI_CTL_AEN 14
`define BDPI_CTL_RESET_VAL 16'h0000
// clock and arbitration tick
`define BDPI_CLK_MHZ 100
`define BDPI_TICK_MHZ 8
// times in ns and their cycle counts
`define BDPI_TIMEOUT_NS 10000
`define BDPI_GAP_NS 1200
`define BDPI_INIT_NS 1000
`define BDPI_RMW_NS 70
`define BDPI_TIMEOUT_CYC ((`BDPI_TIMEOUT_NS * `BDPI_CLK_MHZ) / 1000)
`define BDPI_GAP_CYC ((`BDPI_GAP_NS * `BDPI_CLK_MHZ) / 1000)
`define BDPI_INIT_CYC ((`BDPI_INIT_NS * `BDPI_CLK_MHZ + 999) / 1000)
`define BDPI_RMW_CYC ((`BDPI_RMW_NS * `BDPI_CLK_MHZ + 999) / 1000)
// address and word counter steps
`define BDPI_ADDR_STEP 16'h0002
`define BDPI_WCNT_STEP 16'h0001
`define BDPI_WCNT_LAST 16'hFFFF
`define BDPI_BURST_LEN 2'h3
`define BDPI_VEC_B_BIT 2
`endif

/* File: bdpi_pkg.sv */
// types shared by the bus dma block
package bdpi_pkg;
  typedef enum logic [2:0] {
    BDPI_IDLE, BDPI_REQ, BDPI_ADDR, BDPI_DIN, BDPI_DOUT, BDPI_RMW, BDPI_GAP
  } bdpi_state_t;
  typedef enum logic [1:0] {BDPI_XF_DATI, BDPI_XF_DATO, BDPI_XF_DATIO} bdpi_xfer_t;
endpackage : bdpi_pkg

/* File: bdpi_pulse_timer.sv */
// retriggerable one-shot timer counting core clock cycles
`timescale 1ns/1ps
module bdpi_pulse_timer #(
  parameter logic [11:0] CYCLES = 12'h001
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic clear,
  output logic running,
  output logic expired
);
  logic [11:0] count_reg;

  // start reloads even while running, so each new phase gets a full window
  always_ff @(posedge core_clk)
  begin
    if (!nrst || clear)
      count_reg <= 12'h000;
    else if (start)
      count_reg <= CYCLES;
    else if (count_reg != 12'h000)
      count_reg <= count_reg - 12'h001;
  end

  // expiry flagged only when the count runs out, not when cleared
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      expired <= 1'b0;
    else
      expired <= !clear && !start && (count_reg == 12'h001);
  end

  assign running = (count_reg != 12'h000);
endmodule : bdpi_pulse_timer

/* File: bdpi_bus_dma.sv */
// bus slave, dma master and vectored interrupt logic of the averager interface
`timescale 1ns/1ps
`include "bdpi_map.svh"
module bdpi_bus_dma #(
  parameter logic [11:0] TIMEOUT_CYC = 12'(`BDPI_TIMEOUT_CYC)
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic dev_addr_match,
  input wire logic bus_sync_n,
  input wire logic [15:0] bus_dal_in,
  output logic [15:0] bus_dal_out,
  output logic bus_dal_oe,
  output logic xcvr_transmit_dir,
  output logic xcvr_receive_dir,
  input wire logic word_read_strobe_n,
  input wire logic high_byte_write_n,
  input wire logic low_byte_write_n,
  output logic slave_reply_n,
  output logic bus_irq_n,
  input wire logic bus_iak_in_n,
  output logic bus_iak_out_n,
  output logic bus_dmr_n,
  input wire logic bus_dmg_in_n,
  output logic bus_dmg_out_n,
  input wire logic bus_reply,
  output logic master_sync,
  output logic address_phase_enable,
  output logic dma_read_strobe,
  output logic dma_input_strobe,
  output logic rmw_output_complete_n,
  input wire logic burst_strap,
  input wire logic [5:0] vec_switch,
  input wire logic sa_cycle_busy,
  input wire logic dma_start_req,
  input wire logic result_load,
  input wire logic [15:0] result_value,
  output logic [15:0] data_out_operand,
  output logic [1:0] ext_addr,
  output logic read_in_select_n,
  output logic read_modify_write_select_n,
  output logic mem_advance,
  output logic internal_init,
  output logic irq_chan_a,
  output logic irq_chan_b,
  output logic chan_a_enabled,
  output logic chan_b_enabled,
  output logic dma_done
);
  localparam int SW = 32;
  logic [SW-1:0] pin_raw, meta_reg, pin_reg;
  logic addr_m, sync_a, iak_a, dmg_a, reply_s, rd_a, hb_a, lb_a, sa_busy;
  logic [15:0] dal_s;
  logic [5:0] vec_s;
  logic strap_s, burst_off_reg;
  bdpi_pkg::bdpi_state_t state_reg, state_next;
  logic [15:0] dma_bus_address_reg, dma_word_counter_reg, data_in_result_reg, ctl_reg;
  logic [15:0] dal_next;
  logic [6:0] phase_reg, phase_sum;
  logic tick8, init_run, init_start, to_run, to_exp, gap_run, gap_start, rmw_run, rmw_start;
  logic slave_act_reg, sync_prev_reg, reply_prev_reg, slave_reply_reg;
  logic [2:0] sel_reg;
  logic reply_set, ctl_high_write, ctl_low_write, ctl_read, vec_act_reg, vec_b_reg;
  logic a_flag_reg, b_flag_reg, a_direct_reg, a_attn_reg, ovf_reg;
  logic [1:0] words_reg;
  logic dal_oe_next, iak_claim, claim_b, dma_go, addr_go, word_end, word_read_strobe;
  logic reply_rise, attn_fire;
  bdpi_pkg::bdpi_xfer_t xfer;

  // two-flop synchronisers for every pin from the bus side
  assign pin_raw = {dev_addr_match, !bus_sync_n, !bus_iak_in_n, !bus_dmg_in_n, bus_reply,
                    !word_read_strobe_n, !high_byte_write_n, !low_byte_write_n,
                    sa_cycle_busy, burst_strap, vec_switch, bus_dal_in};
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        meta_reg[gi] <= pin_raw[gi];
        pin_reg[gi] <= meta_reg[gi];
      end
    end
  endgenerate
  assign {addr_m, sync_a, iak_a, dmg_a, reply_s, rd_a, hb_a, lb_a, sa_busy, strap_s, vec_s,
          dal_s} = pin_reg;

  // transfer type from the two active-low controls; DATIO wins over read-in
  function automatic bdpi_pkg::bdpi_xfer_t xfer_decode(input logic rin_n, input logic rmw_n);
    if (!rmw_n)
      return bdpi_pkg::BDPI_XF_DATIO;
    else if (!rin_n)
      return bdpi_pkg::BDPI_XF_DATI;
    else
      return bdpi_pkg::BDPI_XF_DATO;
  endfunction : xfer_decode

  // register select from latched address lines
  function automatic logic sel_is(input logic [2:0] sel, input logic [2:0] ofs);
    return (sel & `BDPI_OFS_MASK) == ofs;
  endfunction : sel_is

  assign read_in_select_n = !ctl_reg[`BDPI_CTL_DATIN];
  assign read_modify_write_select_n = !ctl_reg[`BDPI_CTL_DATIO];
  assign xfer = xfer_decode(read_in_select_n, read_modify_write_select_n);

  // strap caught while bus init is held, stable afterwards
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      burst_off_reg <= strap_s;
  end

  // fractional divider: 8 ticks per 100 core cycles gives the 8 MHz pacing
  assign phase_sum = phase_reg + 7'(`BDPI_TICK_MHZ);
  assign tick8 = (phase_sum >= 7'(`BDPI_CLK_MHZ));
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      phase_reg <= 7'h00;
    else
      phase_reg <= tick8 ? phase_sum - 7'(`BDPI_CLK_MHZ) : phase_sum;
  end

  // timers: init pulse, address timeout, release gap, write-back pulse
  assign init_start = ctl_low_write && dal_s[`BDPI_CTL_RESET];
  bdpi_pulse_timer #(.CYCLES(12'(`BDPI_INIT_CYC))) u_init (.core_clk(core_clk), .nrst(nrst),
    .start(init_start), .clear(1'b0), .running(init_run), .expired());
  bdpi_pulse_timer #(.CYCLES(TIMEOUT_CYC)) u_tout (.core_clk(core_clk), .nrst(nrst),
    .start(addr_go),
    .clear((reply_rise && state_reg == bdpi_pkg::BDPI_ADDR) || internal_init),
    .running(to_run), .expired(to_exp));
  bdpi_pulse_timer #(.CYCLES(12'(`BDPI_GAP_CYC))) u_gap (.core_clk(core_clk), .nrst(nrst),
    .start(gap_start), .clear(internal_init), .running(gap_run), .expired());
  bdpi_pulse_timer #(.CYCLES(12'(`BDPI_RMW_CYC))) u_rmw (.core_clk(core_clk), .nrst(nrst),
    .start(rmw_start), .clear(internal_init), .running(rmw_run), .expired());
  assign internal_init = !nrst || init_run;

  // slave access: latch select at sync, reply once a strobe is seen
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      slave_act_reg <= 1'b0;
      sel_reg <= 3'h0;
      sync_prev_reg <= 1'b0;
      slave_reply_reg <= 1'b0;
    end
    else
    begin
      sync_prev_reg <= sync_a;
      if (sync_a && !sync_prev_reg && addr_m && state_reg == bdpi_pkg::BDPI_IDLE)
      begin
        slave_act_reg <= 1'b1;
        sel_reg <= dal_s[2:0];
      end
      else if (!sync_a)
        slave_act_reg <= 1'b0;
      slave_reply_reg <= slave_act_reg && (rd_a || hb_a || lb_a);
    end
  end
  assign reply_set = slave_act_reg && (rd_a || hb_a || lb_a) && !slave_reply_reg;
  assign word_read_strobe = reply_set && rd_a;
  assign ctl_read = word_read_strobe && sel_is(sel_reg, `BDPI_OFS_CTL);
  assign ctl_high_write = reply_set && hb_a && sel_is(sel_reg, `BDPI_OFS_CTL);
  assign ctl_low_write = reply_set && lb_a && sel_is(sel_reg, `BDPI_OFS_CTL);
  assign slave_reply_n = !(slave_reply_reg || vec_act_reg);

  // address and word counters: byte writes, or step at each address phase
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      dma_bus_address_reg <= 16'h0000;
      dma_word_counter_reg <= 16'h0000;
    end
    else if (addr_go)
    begin
      dma_bus_address_reg <= dma_bus_address_reg + `BDPI_ADDR_STEP;
      dma_word_counter_reg <= dma_word_counter_reg + `BDPI_WCNT_STEP;
    end
    else if (reply_set)
    begin
      if (sel_is(sel_reg, `BDPI_OFS_ADDR) && hb_a)
        dma_bus_address_reg[15:8] <= dal_s[15:8];
      if (sel_is(sel_reg, `BDPI_OFS_ADDR) && lb_a)
        dma_bus_address_reg[7:0] <= dal_s[7:0];
      if (sel_is(sel_reg, `BDPI_OFS_WCNT) && hb_a)
        dma_word_counter_reg[15:8] <= dal_s[15:8];
      if (sel_is(sel_reg, `BDPI_OFS_WCNT) && lb_a)
        dma_word_counter_reg[7:0] <= dal_s[7:0];
    end
  end

  // operand loads from program byte writes or dma input phase; result from the adder
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      data_out_operand <= 16'h0000;
      data_in_result_reg <= 16'h0000;
      mem_advance <= 1'b0;
    end
    else
    begin
      if (state_reg == bdpi_pkg::BDPI_DIN && reply_rise)
        data_out_operand <= dal_s;
      else if (reply_set && sel_is(sel_reg, `BDPI_OFS_DATA))
      begin
        if (hb_a)
          data_out_operand[15:8] <= dal_s[15:8];
        if (lb_a)
          data_out_operand[7:0] <= dal_s[7:0];
      end
      if (result_load)
        data_in_result_reg <= result_value;
      mem_advance <= reply_set && sel_is(sel_reg, `BDPI_OFS_DATA);
    end
  end

  // control register; software low-byte writes win over hardware clears of start and attention
  always_ff @(posedge core_clk)
  begin
    if (internal_init)
      ctl_reg <= `BDPI_CTL_RESET_VAL;
    else
    begin
      if (ctl_low_write)
        ctl_reg[7:0] <= dal_s[7:0] & ~(8'h01 << `BDPI_CTL_RESET);
      else
      begin
        // start holds until the request really goes out, not just one idle cycle
        if (state_reg == bdpi_pkg::BDPI_IDLE && state_next == bdpi_pkg::BDPI_REQ)
          ctl_reg[`BDPI_CTL_START] <= 1'b0;
        if (attn_fire)
          ctl_reg[`BDPI_CTL_ATTN] <= 1'b0;
      end
      if (ctl_high_write)
      begin
        ctl_reg[`BDPI_CTL_AEN] <= dal_s[`BDPI_CTL_AEN];
        ctl_reg[`BDPI_CTL_BEN] <= dal_s[`BDPI_CTL_BEN];
      end
    end
  end
  assign ext_addr = ctl_reg[`BDPI_CTL_XAD17:`BDPI_CTL_XAD16];
  assign chan_a_enabled = ctl_reg[`BDPI_CTL_AEN];
  assign chan_b_enabled = ctl_reg[`BDPI_CTL_BEN];

  // attention waits for both dma and averaging cycle to be idle
  assign attn_fire = ctl_reg[`BDPI_CTL_ATTN] && state_reg == bdpi_pkg::BDPI_IDLE && !sa_busy;

  // interrupt sources; acknowledge clears the serviced channel, a new set wins
  always_ff @(posedge core_clk)
  begin
    if (internal_init)
    begin
      a_flag_reg <= 1'b0;
      b_flag_reg <= 1'b0;
      a_direct_reg <= 1'b0;
      a_attn_reg <= 1'b0;
    end
    else
    begin
      if (to_exp)
        a_flag_reg <= 1'b1;
      else if ((iak_claim && !claim_b) || ctl_high_write)
        a_flag_reg <= ctl_high_write && dal_s[`BDPI_CTL_AFLAG];
      if (word_end && ovf_reg)
        b_flag_reg <= 1'b1;
      else if ((iak_claim && claim_b) || ctl_high_write)
        b_flag_reg <= ctl_high_write && dal_s[`BDPI_CTL_BFLAG];
      if (ctl_high_write && dal_s[`BDPI_CTL_AREQ])
        a_direct_reg <= 1'b1;
      else if (iak_claim && !claim_b)
        a_direct_reg <= 1'b0;
      if (attn_fire)
        a_attn_reg <= 1'b1;
      else if (iak_claim && !claim_b)
        a_attn_reg <= 1'b0;
    end
  end
  assign irq_chan_a = chan_a_enabled && (a_flag_reg || a_direct_reg || a_attn_reg);
  assign irq_chan_b = chan_b_enabled && b_flag_reg;
  assign bus_irq_n = !(irq_chan_a || irq_chan_b);

  // acknowledge chain: claim if requesting, else pass it on
  assign iak_claim = iak_a && !vec_act_reg && (irq_chan_a || irq_chan_b);
  assign claim_b = !irq_chan_a;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      vec_act_reg <= 1'b0;
      vec_b_reg <= 1'b0;
    end
    else if (iak_claim)
    begin
      vec_act_reg <= 1'b1;
      vec_b_reg <= claim_b;
    end
    else if (!iak_a)
      vec_act_reg <= 1'b0;
  end
  assign bus_iak_out_n = !(iak_a && !vec_act_reg && !irq_chan_a && !irq_chan_b);

  // dma sequencer: request, grant, write-back end and gap end wait for the 8 MHz tick; replies and timeout act at once
  assign dma_go = ctl_reg[`BDPI_CTL_START] || dma_start_req;
  assign reply_rise = reply_s && !reply_prev_reg;
  always_comb
  begin
    state_next = state_reg;
    addr_go = 1'b0;
    word_end = 1'b0;
    gap_start = 1'b0;
    rmw_start = 1'b0;
    case (state_reg)
      bdpi_pkg::BDPI_IDLE:
        if (dma_go && tick8 && !slave_act_reg)
          state_next = bdpi_pkg::BDPI_REQ;
      bdpi_pkg::BDPI_REQ:
        if (dmg_a && tick8)
        begin
          state_next = bdpi_pkg::BDPI_ADDR;
          addr_go = 1'b1;
        end
      bdpi_pkg::BDPI_ADDR:
        if (to_exp)
          state_next = bdpi_pkg::BDPI_IDLE;
        else if (reply_rise)
          state_next = (xfer == bdpi_pkg::BDPI_XF_DATO) ? bdpi_pkg::BDPI_DOUT
                                                         : bdpi_pkg::BDPI_DIN;
      bdpi_pkg::BDPI_DIN:
        if (reply_rise && xfer == bdpi_pkg::BDPI_XF_DATIO)
          state_next = bdpi_pkg::BDPI_DOUT;
        else if (reply_rise)
          word_end = 1'b1;
      bdpi_pkg::BDPI_DOUT:
        if (reply_rise && xfer == bdpi_pkg::BDPI_XF_DATIO)
        begin
          state_next = bdpi_pkg::BDPI_RMW;
          rmw_start = 1'b1;
        end
        else if (reply_rise)
          word_end = 1'b1;
      bdpi_pkg::BDPI_RMW:
        if (!rmw_run && tick8)
          word_end = 1'b1;
      bdpi_pkg::BDPI_GAP:
        if (!gap_run && tick8)
          state_next = bdpi_pkg::BDPI_REQ;
      default:
        state_next = bdpi_pkg::BDPI_IDLE;
    endcase
    if (word_end)
    begin
      if (ovf_reg)
        state_next = bdpi_pkg::BDPI_IDLE;
      else if (!burst_off_reg && words_reg == `BDPI_BURST_LEN)
      begin
        state_next = bdpi_pkg::BDPI_GAP;
        gap_start = 1'b1;
      end
      else
      begin
        state_next = bdpi_pkg::BDPI_ADDR;
        addr_go = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (internal_init)
    begin
      state_reg <= bdpi_pkg::BDPI_IDLE;
      reply_prev_reg <= 1'b0;
      words_reg <= 2'h0;
      ovf_reg <= 1'b0;
      address_phase_enable <= 1'b0;
      dma_done <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      reply_prev_reg <= reply_s;
      address_phase_enable <= addr_go;
      dma_done <= word_end && ovf_reg;
      if (addr_go)
        ovf_reg <= (dma_word_counter_reg == `BDPI_WCNT_LAST);
      if (word_end)
        words_reg <= words_reg + 2'h1;
      else if (state_reg == bdpi_pkg::BDPI_IDLE)
        words_reg <= 2'h0;
    end
  end

  // bus request asserted only in the request state, so it drops once the grant starts the address phase
  assign bus_dmr_n = !(state_reg == bdpi_pkg::BDPI_REQ);
  assign bus_dmg_out_n = !(dmg_a && (state_reg == bdpi_pkg::BDPI_IDLE
                                     || state_reg == bdpi_pkg::BDPI_GAP));
  assign master_sync = state_reg == bdpi_pkg::BDPI_ADDR || state_reg == bdpi_pkg::BDPI_DIN
                       || state_reg == bdpi_pkg::BDPI_DOUT || state_reg == bdpi_pkg::BDPI_RMW;
  assign dma_input_strobe = state_reg == bdpi_pkg::BDPI_DIN;
  assign dma_read_strobe = state_reg == bdpi_pkg::BDPI_DOUT;
  assign rmw_output_complete_n = !rmw_run;

  // data bus driver mux, registered so drive data and enable move together
  always_comb
  begin
    dal_next = 16'h0000;
    dal_oe_next = 1'b1;
    // the register stepped as the phase began, so drive the address it held
    if (state_reg == bdpi_pkg::BDPI_ADDR)
      dal_next = dma_bus_address_reg - `BDPI_ADDR_STEP;
    else if (state_reg == bdpi_pkg::BDPI_DOUT)
      dal_next = data_in_result_reg;
    else if (iak_claim || vec_act_reg)
    begin
      dal_next = {7'h00, vec_s, 3'h0};
      dal_next[`BDPI_VEC_B_BIT] = iak_claim ? claim_b : vec_b_reg;
    end
    else if (slave_act_reg && rd_a)
    begin
      if (sel_is(sel_reg, `BDPI_OFS_ADDR))
        dal_next = dma_bus_address_reg;
      else if (sel_is(sel_reg, `BDPI_OFS_WCNT))
        dal_next = dma_word_counter_reg;
      else if (sel_is(sel_reg, `BDPI_OFS_CTL) || ctl_read)
      begin
        dal_next = ctl_reg;
        dal_next[`BDPI_CTL_AFLAG] = a_flag_reg;
        dal_next[`BDPI_CTL_BFLAG] = b_flag_reg;
        dal_next[`BDPI_CTL_AREQ] = a_direct_reg;
        dal_next[`BDPI_CTL_READY] = state_reg == bdpi_pkg::BDPI_IDLE;
      end
      else
        dal_next = data_in_result_reg;
    end
    else
      dal_oe_next = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bus_dal_out <= 16'h0000;
      bus_dal_oe <= 1'b0;
    end
    else
    begin
      bus_dal_out <= dal_next;
      bus_dal_oe <= dal_oe_next;
    end
  end
  assign xcvr_transmit_dir = bus_dal_oe;
  assign xcvr_receive_dir = !bus_dal_oe;
endmodule : bdpi_bus_dma

/* File: bdpi_bus_dma_asserts.sv */
// port assertions for the bus dma block
`timescale 1ns/1ps
module bdpi_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic bus_dal_oe,
  input wire logic xcvr_transmit_dir,
  input wire logic xcvr_receive_dir,
  input wire logic bus_irq_n,
  input wire logic irq_chan_a,
  input wire logic irq_chan_b,
  input wire logic address_phase_enable,
  input wire logic dma_read_strobe,
  input wire logic dma_input_strobe,
  input wire logic rmw_output_complete_n,
  input wire logic read_modify_write_select_n,
  input wire logic internal_init,
  input wire logic chan_a_enabled,
  input wire logic chan_b_enabled,
  input wire logic bus_dmr_n
);
  default clocking @(posedge core_clk);
  endclocking
  // reset ones carry no disable, they must hold while reset is low
  property p_xcvr;
    disable iff (!nrst) xcvr_transmit_dir == bus_dal_oe && xcvr_receive_dir != bus_dal_oe;
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver direction wrong");
  property p_irq;
    disable iff (!nrst) bus_irq_n == !(irq_chan_a || irq_chan_b);
  endproperty
  a_irq: assert property (p_irq) else $error("bus interrupt line wrong");
  property p_init;
    !nrst [*4] |-> internal_init;
  endproperty
  a_init: assert property (p_init) else $error("init not following bus init");
  property p_rst;
    !nrst [*4] |=> bus_dmr_n && !chan_a_enabled && !chan_b_enabled && !irq_chan_a;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by init");
  property p_rmw;
    disable iff (!nrst) $fell(rmw_output_complete_n) |->
      !rmw_output_complete_n [*7] ##1 rmw_output_complete_n;
  endproperty
  a_rmw: assert property (p_rmw) else $error("write-back pulse length wrong");
  property p_rmwsel;
    disable iff (!nrst) !rmw_output_complete_n |-> !read_modify_write_select_n;
  endproperty
  a_rmwsel: assert property (p_rmwsel) else $error("write-back outside rmw");
  property p_ape;
    disable iff (!nrst) address_phase_enable |=> !address_phase_enable;
  endproperty
  a_ape: assert property (p_ape) else $error("address phase pulse too long");
  property p_strb;
    disable iff (!nrst) !(dma_read_strobe && dma_input_strobe);
  endproperty
  a_strb: assert property (p_strb) else $error("both dma strobes high");
endmodule : bdpi_chk
bind bdpi_bus_dma bdpi_chk i_bdpi_chk (.*);

/* File: bdpi_bus_mem.sv */
// far side model: bus arbiter plus memory answering master cycles
`timescale 1ns/1ps
module bdpi_bus_mem (
  input wire logic core_clk,
  input wire logic present,
  input wire logic bus_dmr_n,
  input wire logic address_phase_enable,
  input wire logic dma_read_strobe,
  input wire logic dma_input_strobe,
  output logic bus_dmg_in_n,
  output logic bus_reply,
  output logic [15:0] mem_data
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] prev = 3'h0;
  initial bus_dmg_in_n = 1'b1;
  // grant follows request one cycle later
  always @(posedge core_clk) bus_dmg_in_n <= bus_dmr_n;
  // each phase start gets one reply pulse; an absent address never answers
  always @(posedge core_clk)
  begin
    prev <= {address_phase_enable, dma_read_strobe, dma_input_strobe};
    if (present && |({address_phase_enable, dma_read_strobe, dma_input_strobe} & ~prev))
      cnt <= 3'h6;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign bus_reply = cnt == 3'h4 || cnt == 3'h3;
  // data flips outside the valid window so stale values never pass
  assign mem_data = (cnt != 3'h0 && cnt < 3'h5) ? 16'hC35A : 16'h3CA5;
endmodule : bdpi_bus_mem

/* File: tb_top.sv */
// self-checking bench for the bus dma block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [2:0] o; logic [1:0] w; logic [15:0] d; logic [15:0] e;} bdpi_row_t;
  logic clk, nrst, sync_n, rd_n, hb_n, lb_n, present, rload, dmg, reply, rep_n, iak_n, dmr_q, ape_d;
  logic oe, irq_n, dmr_n, msync, ape, rs, istb, ris_n, rms_n, adv, init, ia, ib, ea, eb, done;
  logic [15:0] dal, mem, dout, rval, opnd, rd, addr_seen;
  logic [1:0] ext;
  int failures, compares, napes, nadv, ninit, nreq, b, n;
  bdpi_row_t rows [7] = '{'{3'h0, 2'h3, 16'hA5C3, 16'hA5C3}, '{3'h0, 2'h2, 16'h1200, 16'h12C3},
    '{3'h0, 2'h1, 16'h0000, 16'h1200}, '{3'h2, 2'h3, 16'h5AA5, 16'h5AA5},
    '{3'h2, 2'h1, 16'hFF3C, 16'h5A3C}, '{3'h6, 2'h3, 16'h0F0F, 16'h9669},
    '{3'h4, 2'h2, 16'h5000, 16'h5080}};
  bdpi_bus_dma #(.TIMEOUT_CYC(12'h032)) i_bdpi_bus_dma (.core_clk(clk), .nrst(nrst),
    .dev_addr_match(!sync_n), .bus_sync_n(sync_n), .bus_dal_in(msync ? mem : dal),
    .bus_dal_out(dout), .bus_dal_oe(oe), .xcvr_transmit_dir(), .xcvr_receive_dir(),
    .word_read_strobe_n(rd_n), .high_byte_write_n(hb_n), .low_byte_write_n(lb_n),
    .slave_reply_n(rep_n), .bus_irq_n(irq_n), .bus_iak_in_n(iak_n), .bus_iak_out_n(),
    .bus_dmr_n(dmr_n), .bus_dmg_in_n(dmg), .bus_dmg_out_n(), .bus_reply(reply),
    .master_sync(msync), .address_phase_enable(ape), .dma_read_strobe(rs),
    .dma_input_strobe(istb), .rmw_output_complete_n(), .burst_strap(1'b0),
    .vec_switch(6'h15), .sa_cycle_busy(1'b0), .dma_start_req(1'b0), .result_load(rload),
    .result_value(rval), .data_out_operand(opnd), .ext_addr(ext), .read_in_select_n(ris_n),
    .read_modify_write_select_n(rms_n), .mem_advance(adv), .internal_init(init),
    .irq_chan_a(ia), .irq_chan_b(ib), .chan_a_enabled(ea), .chan_b_enabled(eb),
    .dma_done(done));
  bdpi_bus_mem i_bdpi_bus_mem (.core_clk(clk), .present(present), .bus_dmr_n(dmr_n),
    .address_phase_enable(ape), .dma_read_strobe(rs), .dma_input_strobe(istb),
    .bus_dmg_in_n(dmg), .bus_reply(reply), .mem_data(mem));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulse counters, init counted only after release
  always @(posedge clk)
  begin
    napes <= napes + int'(ape);
    nadv <= nadv + int'(adv);
    ninit <= ninit + int'(init & nrst);
    dmr_q <= dmr_n;
    nreq <= nreq + int'(dmr_q & !dmr_n);
    ape_d <= ape;
    // drive data lags the phase pulse by one register stage
    if (ape_d)
      addr_seen <= dout;
  end
  task automatic give_verdict();
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // bounded wait; running out ends the run as a mismatch
  task automatic wt(ref logic s, input logic lvl);
    int k;
    k = 0;
    while (s !== lvl && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 3000)
    begin
      failures++;
      give_verdict();
    end
  endtask : wt
  // one slave cycle: sync with address, then strobe held until reply
  task automatic acc(input logic [2:0] o, input logic [1:0] w, input logic [15:0] d);
    @(posedge clk);
    sync_n <= 1'b0;
    dal <= {13'h0000, o};
    repeat (3) @(posedge clk);
    dal <= d;
    rd_n <= w != 2'h0;
    hb_n <= !w[1];
    lb_n <= !w[0];
    wt(rep_n, 1'b0);
    rd = dout;
    {rd_n, hb_n, lb_n} <= 3'h7;
    wt(rep_n, 1'b1);
    sync_n <= 1'b1;
    dal <= ~d;
  endtask : acc
  initial
  begin
    {failures, compares, napes, nadv, ninit, nreq} = '0;
    {nrst, sync_n, rd_n, hb_n, lb_n, present, rload, iak_n, dal, rval} = {8'h7D, 32'h00000000};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rload <= 1'b1;
    rval <= 16'h9669;
    @(posedge clk);
    rload <= 1'b0;
    foreach (rows[i])
    begin
      acc(rows[i].o, rows[i].w, rows[i].d);
      acc(rows[i].o, 2'h0, 16'h0000);
      chk(rd, rows[i].e, "readback");
    end
    chk(opnd, 16'h0F0F, "operand");
    chk(16'(nadv), 16'h0002, "advances");
    chk({14'h0000, ea, eb}, 16'h0003, "enables");
    acc(3'h0, 2'h3, 16'h1000);
    acc(3'h2, 2'h3, 16'hFFFE);
    acc(3'h4, 2'h1, 16'h0035);
    chk({12'h000, ext, ris_n, rms_n}, 16'h000D, "mode");
    wt(done, 1'b1);
    repeat (3) @(posedge clk);
    chk({15'h0000, ib}, 16'h0001, "b request");
    chk(opnd, 16'hC35A, "dma data");
    chk(addr_seen, 16'h1002, "driven address");
    // acknowledge while only channel B requests: vector with the B bit, source cleared
    iak_n <= 1'b0;
    wt(rep_n, 1'b0);
    chk(dout, 16'h00AC, "vector");
    iak_n <= 1'b1;
    wt(rep_n, 1'b1);
    chk({15'h0000, ib}, 16'h0000, "b cleared");
    acc(3'h0, 2'h0, 16'h0000);
    chk(rd, 16'h1004, "address");
    acc(3'h2, 2'h0, 16'h0000);
    chk(rd, 16'h0000, "count");
    acc(3'h2, 2'h3, 16'hFFF8);
    acc(3'h4, 2'h1, 16'h0009);
    wt(done, 1'b1);
    chk(16'(napes), 16'h000A, "phases");
    chk(16'(nreq), 16'h0003, "requests");
    present <= 1'b0;
    acc(3'h2, 2'h3, 16'hFFFF);
    acc(3'h4, 2'h1, 16'h0001);
    wt(ia, 1'b1);
    repeat (3) @(posedge clk);
    chk({14'h0000, dmr_n, irq_n}, 16'h0002, "timeout");
    b = ninit;
    acc(3'h4, 2'h1, 16'h0002);
    repeat (150) @(posedge clk);
    chk(16'(ninit - b), 16'h0064, "init pulse");
    chk({14'h0000, ea, ia}, 16'h0000, "init clear");
    give_verdict();
  end
endmodule : tb_top
